// ==== hdl/ssu_defines.vh ====
// Constants for the string store unit
`ifndef SSU_DEFINES_VH
`define SSU_DEFINES_VH
`define SSU_OPC_BYTE 8'hAA
`define SSU_OPC_WORD 8'hAB
`define SSU_CLK_NS 100
`define SSU_BYTE_CLOCKS 4'hA
`define SSU_WORD16_CLOCKS 4'hA
`define SSU_WORD8_CLOCKS 4'hE
`define SSU_STEP_BYTE 16'h0001
`define SSU_STEP_WORD 16'h0002
`define SSU_ST_IDLE 2'h0
`define SSU_ST_EXEC 2'h1
`define SSU_ST_PUSH 2'h2
`define SSU_ST_DONE 2'h3
`endif

// ==== hdl/ssu_skid.v ====
// Two-entry buffer between store engine and memory write path
`timescale 1ns/10ps
`default_nettype none
module ssu_skid
(
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Fill side
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [36:0] in_data_in,
  // Drain side
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [36:0] out_data_out
);
  reg [36:0] mem [0:1];
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] count;
  wire push;
  wire pop;
  assign in_ready_out = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data_in;
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push & ~pop)
        count <= count + 2'h1;
      else if (pop & ~push)
        count <= count - 2'h1;
    end
  end
endmodule // ssu_skid
`default_nettype wire

// ==== hdl/ssu_top.v ====
// String store execution unit
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "ssu_defines.vh"
module ssu_top
(
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Instruction start
  input wire start_in,
  input wire [7:0] opcode_in,
  input wire repeat_prefix_in,
  input wire segment_override_in,
  input wire narrow_bus_in,
  // Architectural state in
  input wire [15:0] accumulator_word_in,
  input wire [15:0] destination_index_in,
  input wire [15:0] extra_segment_in,
  input wire [15:0] count_register_in,
  input wire direction_flag_in,
  input wire [15:0] status_flags_in,
  // Architectural state out
  output reg [15:0] destination_index_out,
  output reg [15:0] count_register_out,
  output reg [15:0] status_flags_out,
  output reg busy_out,
  output reg done_out,
  output reg illegal_out,
  // Memory write path
  output reg mem_valid_out,
  input wire mem_ready_in,
  output reg [19:0] mem_addr_out,
  output reg [15:0] mem_data_out,
  output reg mem_word_out
);
  reg [1:0] state;
  reg [3:0] cyc;
  reg [3:0] cyc_limit;
  reg word_mode;
  reg rep_mode;
  reg dir;
  reg [15:0] acc;
  reg [15:0] seg;
  reg [15:0] di;
  reg [15:0] cnt;
  reg buf_valid;
  wire buf_ready;
  wire drain_valid;
  wire [36:0] drain_data;
  wire drain_ready;
  wire [15:0] step;
  wire [19:0] phys_addr;
  wire [15:0] wdata;
  // Segment is never overridden; operand never enters the address
  assign phys_addr = {seg, 4'h0} + {4'h0, di};
  assign wdata = word_mode ? acc : {8'h00, acc[7:0]};
  assign step = word_mode ? `SSU_STEP_WORD : `SSU_STEP_BYTE;
  assign drain_ready = ~mem_valid_out | mem_ready_in;

  ssu_skid u_skid
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(buf_valid),
    .in_ready_out(buf_ready),
    .in_data_in({word_mode, phys_addr, wdata}),
    .out_valid_out(drain_valid),
    .out_ready_in(drain_ready),
    .out_data_out(drain_data)
  );

  // Memory request register
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      mem_valid_out <= 1'b0;
      mem_addr_out <= 20'h00000;
      mem_data_out <= 16'h0000;
      mem_word_out <= 1'b0;
    end
    else if (drain_ready)
    begin
      mem_valid_out <= drain_valid;
      if (drain_valid)
      begin
        mem_word_out <= drain_data[36];
        mem_addr_out <= drain_data[35:16];
        mem_data_out <= drain_data[15:0];
      end
    end
  end

  // Store sequencer
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state <= `SSU_ST_IDLE;
      cyc <= 4'h0;
      cyc_limit <= 4'h0;
      word_mode <= 1'b0;
      rep_mode <= 1'b0;
      dir <= 1'b0;
      acc <= 16'h0000;
      seg <= 16'h0000;
      di <= 16'h0000;
      cnt <= 16'h0000;
      buf_valid <= 1'b0;
      destination_index_out <= 16'h0000;
      count_register_out <= 16'h0000;
      status_flags_out <= 16'h0000;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      illegal_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      illegal_out <= 1'b0;
      case (state)
        `SSU_ST_IDLE:
        begin
          if (start_in)
          begin
            status_flags_out <= status_flags_in;
            if (opcode_in == `SSU_OPC_BYTE || opcode_in == `SSU_OPC_WORD)
            begin
              word_mode <= (opcode_in == `SSU_OPC_WORD);
              rep_mode <= repeat_prefix_in;
              dir <= direction_flag_in;
              acc <= accumulator_word_in;
              seg <= extra_segment_in;
              di <= destination_index_in;
              cnt <= count_register_in;
              destination_index_out <= destination_index_in;
              count_register_out <= count_register_in;
              // Cycle budget per element
              if (opcode_in == `SSU_OPC_WORD && narrow_bus_in)
                cyc_limit <= `SSU_WORD8_CLOCKS - 4'h1;
              else if (opcode_in == `SSU_OPC_WORD)
                cyc_limit <= `SSU_WORD16_CLOCKS - 4'h1;
              else
                cyc_limit <= `SSU_BYTE_CLOCKS - 4'h1;
              cyc <= 4'h0;
              busy_out <= 1'b1;
              if (repeat_prefix_in && count_register_in == 16'h0000)
                state <= `SSU_ST_DONE;
              else
              begin
                buf_valid <= 1'b1;
                state <= `SSU_ST_PUSH;
              end
            end
            else
              illegal_out <= 1'b1;
          end
        end
        `SSU_ST_PUSH:
        begin
          cyc <= cyc + 4'h1;
          if (buf_ready)
          begin
            buf_valid <= 1'b0;
            state <= `SSU_ST_EXEC;
          end
        end
        `SSU_ST_EXEC:
        begin
          if (cyc < cyc_limit)
            cyc <= cyc + 4'h1;
          else
          begin
            cyc <= 4'h0;
            // Index steps after every element
            if (dir)
            begin
              di <= di - step;
              destination_index_out <= di - step;
            end
            else
            begin
              di <= di + step;
              destination_index_out <= di + step;
            end
            if (rep_mode)
            begin
              cnt <= cnt - 16'h0001;
              count_register_out <= cnt - 16'h0001;
              if (cnt == 16'h0001)
                state <= `SSU_ST_DONE;
              else
              begin
                buf_valid <= 1'b1;
                state <= `SSU_ST_PUSH;
              end
            end
            else
              state <= `SSU_ST_DONE;
          end
        end
        default:
        begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          state <= `SSU_ST_IDLE;
        end
      endcase
    end
  end
endmodule // ssu_top
`default_nettype wire

// ==== dv/ssu_mem_model.sv ====
// Memory write sink for the string store unit
`timescale 1ns/10ps
`default_nettype none
module ssu_mem_model
(
  // Control
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic stall_in,
  // Write path
  input wire logic v_in,
  output logic rdy_out,
  input wire logic [36:0] w_in,
  // Results
  output logic [7:0] n_out,
  output logic [36:0] last_out
);
  assign rdy_out = !stall_in;
  always_ff @(posedge clk_in)
    if (rst_in)
      n_out <= 8'h00;
    else if (v_in && rdy_out)
    begin
      n_out <= n_out + 8'h01;
      last_out <= w_in;
    end
endmodule // ssu_mem_model
`default_nettype wire

// ==== dv/ssu_props.sv ====
// Port assertions for the string store unit
`timescale 1ns/10ps
`default_nettype none
module ssu_props
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Watched ports
  input wire logic start_in,
  input wire logic [7:0] opcode_in,
  input wire logic repeat_prefix_in,
  input wire logic [15:0] count_register_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic illegal_out,
  input wire logic mem_valid_out,
  input wire logic mem_ready_in
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  wire go = start_in && !busy_out;
  wire st = opcode_in == 8'hAA || opcode_in == 8'hAB;
  wire z = repeat_prefix_in && count_register_in == 16'h0000;
  bad_op_a: assert property (go && !st |=> illegal_out && !busy_out)
    else $error("bad opcode");
  refusal_pulse_a: assert property (illegal_out && !start_in |-> !busy_out ##1 !illegal_out)
    else $error("long refusal");
  store_start_a: assert property (go && st && !z |=> busy_out)
    else $error("no start");
  first_write_a: assert property (go && st && !z |-> ##[1:4] mem_valid_out)
    else $error("no write");
  zero_count_a: assert property (go && st && z |=> !mem_valid_out ##1 done_out)
    else $error("zero count");
  early_done_a: assert property (go && st && !z |=> !done_out [*8])
    else $error("early end");
  write_hold_a: assert property (mem_valid_out && !mem_ready_in |=> mem_valid_out)
    else $error("write dropped");
  done_pulse_a: assert property (done_out |-> !busy_out && !mem_valid_out ##1 !done_out)
    else $error("bad done");
endmodule // ssu_props
`default_nettype wire

// ==== dv/ssu_tb.sv ====
// Self-checking bench for the string store unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_in = 0, rst_in = 1, start_in = 0, repeat_prefix_in = 0, narrow_bus_in = 0;
  logic direction_flag_in = 0, segment_override_in = 1, stall = 0, busy_out, done_out;
  logic illegal_out, mem_valid_out, mem_ready_in, mem_word_out;
  logic [7:0] opcode_in = 0, wr_n;
  logic [15:0] accumulator_word_in = 16'hC35A, destination_index_in = 16'h0010;
  logic [15:0] extra_segment_in = 16'h1234, status_flags_in = 16'hA5C3;
  logic [15:0] count_register_in = 0, destination_index_out, count_register_out;
  logic [15:0] status_flags_out, mem_data_out;
  logic [19:0] mem_addr_out;
  logic [36:0] last;
  wire [60:0] seen = {wr_n, last, destination_index_out};
  int error_cnt = 0, checked = 0, cyc;
  always #50 clk_in = ~clk_in;
  ssu_top ssu_top_inst (.*);
  ssu_mem_model ssu_mem_model_inst (.clk_in, .rst_in, .stall_in(stall), .v_in(mem_valid_out),
    .rdy_out(mem_ready_in), .w_in({mem_word_out, mem_addr_out, mem_data_out}), .n_out(wr_n),
    .last_out(last));
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [7:0] o, input logic r, d, n, input logic [15:0] c);
    @(posedge clk_in);
    {opcode_in, repeat_prefix_in, direction_flag_in, narrow_bus_in, count_register_in,
      start_in} <= {o, r, d, n, c, 1'h1};
    @(posedge clk_in);
    start_in <= 1'h0;
    cyc = 0;
    do
    begin
      @(negedge clk_in);
      cyc++;
    end
    while (done_out !== 1'h1 && illegal_out !== 1'h1 && cyc < 300);
    $display("test %h: %0d cycles", o, cyc);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'h0;
    run(8'hAA, 0, 0, 0, 16'h0005);
    chk(seen, {8'h01, 1'h0, 20'h12350, 16'h005A, 16'h0011});
    chk(cyc >= 10 && cyc <= 13, 1'h1);
    run(8'hAB, 0, 1, 1, 16'h0005);
    chk(seen, {8'h02, 1'h1, 20'h12350, 16'hC35A, 16'h000E});
    chk(cyc >= 14 && cyc <= 17, 1'h1);
    chk(status_flags_out, 16'hA5C3);
    fork
      run(8'hAA, 1, 1, 0, 16'h0004);
      begin
        @(posedge clk_in);
        stall <= 1'h1;
        repeat (40) @(posedge clk_in);
        stall <= 1'h0;
      end
    join
    chk(seen, {8'h06, 1'h0, 20'h1234D, 16'h005A, 16'h000C});
    chk(count_register_out, 16'h0000);
    run(8'hAB, 1, 0, 0, 16'h0000);
    chk({wr_n, last, cyc[7:0]}, {8'h06, 1'h0, 20'h1234D, 16'h005A, 8'h02});
    run(8'h90, 0, 0, 0, 16'h0005);
    chk({illegal_out, wr_n, cyc[7:0]}, {1'h1, 8'h06, 8'h01});
    run(8'hAB, 0, 0, 0, 16'h0005);
    chk(seen, {8'h07, 1'h1, 20'h12350, 16'hC35A, 16'h0012});
    chk(cyc >= 10 && cyc <= 13, 1'h1);
    print_verdict;
  end
  initial
  begin
    repeat (3000) @(posedge clk_in);
    error_cnt++;
    print_verdict;
  end
  task automatic print_verdict;
    $display("%0d checks, %0d wrong", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
endmodule // testbench
bind ssu_top ssu_props ssu_props_inst (.*);
`default_nettype wire
